/* rtl/dacsw_dev.sv */
// Converter end: serial word receiver, code and power mode registers
// Assumes link pins are asynchronous to i_sys_clk
`timescale 1ns/10ps
module dacsw_dev
  import dacsw_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // Link
  dacsw_link_if.dev link,
  // Analog control
  output logic [9:0] o_dac_code,
  output logic [1:0] o_mode,
  output logic o_power_down,
  output logic o_pd_1k,
  output logic o_pd_100k,
  output logic o_pd_hiz,
  output logic o_update
);
  // ------------------------------------------------------------
  // Synchronisers
  // ------------------------------------------------------------
  // Pins are asynchronous to i_sys_clk, so each passes two flops first
  logic [2:0] pin_raw;
  logic [2:0] pin_sync;
  logic sync_n_q;
  logic sclk_q;
  logic sdata_q;
  logic sync_n_d;
  logic sclk_d;
  logic sync_fall;
  logic fall_sclk;
  logic frame_on;
  logic take_bit;
  logic last_bit;
  logic [4:0] bit_cnt;
  logic [15:0] shift;
  logic [15:0] next_shift;
  logic apply;
  logic [1:0] new_mode;
  logic [9:0] new_code;

  assign pin_raw = {link.sync_n, link.sclk, link.sdata};

  for (genvar p = 0; p < 3; p++)
  begin : g_pin_sync
    logic meta;
    logic held;
    always_ff @(posedge i_sys_clk)
    begin
      meta <= pin_raw[p];
      held <= meta;
    end
    assign pin_sync[p] = held;
  end

  assign sync_n_q = pin_sync[2];
  assign sclk_q = pin_sync[1];
  assign sdata_q = pin_sync[0];

  // ------------------------------------------------------------
  // Edge detection
  // ------------------------------------------------------------
  // Both start at the parked low level, so reset makes no false edge
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      sync_n_d <= 1'b0;
    end
    else
    begin
      sync_n_d <= sync_n_q;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      sclk_d <= 1'b0;
    end
    else
    begin
      sclk_d <= sclk_q;
    end
  end

  assign sync_fall = sync_n_d & ~sync_n_q;
  assign fall_sclk = sclk_d & ~sclk_q;

  // ------------------------------------------------------------
  // Frame tracking
  // ------------------------------------------------------------
  // Frame opens only on a select fall, so a held-low select cannot rearm
  assign take_bit = frame_on & fall_sclk & ~sync_n_q & ~sync_n_d;
  assign last_bit = bit_cnt == 5'(DACSW_WORD_BITS - 1);
  // First bit in ends at the top of the word
  assign next_shift = {shift[14:0], sdata_q};

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      frame_on <= 1'b0;
    end
    else if (sync_n_q)
    begin
      frame_on <= 1'b0;
    end
    else if (sync_fall)
    begin
      frame_on <= 1'b1;
    end
    else if (take_bit && last_bit)
    begin
      frame_on <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      bit_cnt <= 5'h00;
    end
    else if (sync_n_q || sync_fall)
    begin
      bit_cnt <= 5'h00;
    end
    else if (take_bit)
    begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      shift <= 16'h0000;
    end
    else if (sync_n_q || sync_fall)
    begin
      shift <= 16'h0000;
    end
    else if (take_bit)
    begin
      shift <= next_shift;
    end
  end

  // ------------------------------------------------------------
  // Apply word
  // ------------------------------------------------------------
  // Bits 15,14 and 1,0 are dropped
  assign apply = take_bit & last_bit;
  assign new_mode = {next_shift[DACSW_MODE_HI_POS], next_shift[DACSW_MODE_LO_POS]};
  assign new_code = next_shift[DACSW_CODE_MSB_POS:DACSW_CODE_LSB_POS];

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      o_update <= 1'b0;
    end
    else
    begin
      o_update <= apply;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      o_mode <= DACSW_MODE_RESET;
    end
    else if (apply)
    begin
      o_mode <= new_mode;
    end
  end

  // A power-down word keeps the code; only a normal-mode word loads its new code
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      o_dac_code <= DACSW_CODE_RESET;
    end
    else if (apply && new_mode == DACSW_MODE_NORMAL)
    begin
      o_dac_code <= new_code;
    end
  end

  // ------------------------------------------------------------
  // Power-down decode
  // ------------------------------------------------------------
  // Shutdown and termination are levels held until the next valid word
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      o_power_down <= 1'b0;
    end
    else if (apply)
    begin
      o_power_down <= new_mode != DACSW_MODE_NORMAL;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      o_pd_1k <= 1'b0;
      o_pd_100k <= 1'b0;
      o_pd_hiz <= 1'b0;
    end
    else if (apply)
    begin
      o_pd_1k <= new_mode == DACSW_MODE_PD_1K;
      o_pd_100k <= new_mode == DACSW_MODE_PD_100K;
      o_pd_hiz <= new_mode == DACSW_MODE_PD_HIZ;
    end
  end
endmodule

/* rtl/dacsw_host.sv */
// Host end: sends one sixteen bit word per request
// Assumes requests come from logic on i_sys_clk
`timescale 1ns/10ps
module dacsw_host
  import dacsw_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // Request
  input wire logic i_req,
  input wire logic [1:0] i_mode,
  input wire logic [9:0] i_code,
  output logic o_busy,
  output logic o_done,
  // Link
  dacsw_link_if.host link
);
  typedef enum logic [2:0] {
    DACSW_ST_IDLE = 3'h1,
    DACSW_ST_SHIFT = 3'h2,
    DACSW_ST_GAP = 3'h4
  } dacsw_state_type;

  dacsw_state_type state;
  logic [15:0] word;
  logic [4:0] bits_left;
  logic [7:0] tick;
  logic phase_hi;
  logic sclk_r;
  logic sync_r;
  logic sdata_r;

  assign link.sclk = sclk_r;
  assign link.sync_n = sync_r;
  assign link.sdata = sdata_r;

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  // Clock idles low and data changes on rising edge, stable at fall
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      state <= DACSW_ST_IDLE;
      word <= 16'h0000;
      bits_left <= 5'h00;
      tick <= 8'h00;
      phase_hi <= 1'b0;
      sclk_r <= 1'b0;
      sync_r <= 1'b0;
      sdata_r <= 1'b0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      case (state)
        DACSW_ST_IDLE:
        begin
          sync_r <= 1'b0;
          sdata_r <= 1'b0;
          sclk_r <= 1'b0;
          if (i_req)
          begin
            word <= {2'h0, i_mode, i_code, 2'h0};
            bits_left <= 5'(DACSW_WORD_BITS);
            sync_r <= 1'b1;
            tick <= 8'(DACSW_SYNC_HIGH_CYC);
            o_busy <= 1'b1;
            state <= DACSW_ST_GAP;
          end
        end
        DACSW_ST_GAP:
        begin
          // Select held high before its fall opens the frame
          if (tick != 8'h00)
          begin
            tick <= tick - 8'h01;
          end
          else
          begin
            sync_r <= 1'b0;
            tick <= 8'(DACSW_SCLK_HALF_CYC);
            phase_hi <= 1'b0;
            state <= DACSW_ST_SHIFT;
          end
        end
        DACSW_ST_SHIFT:
        begin
          if (tick != 8'h00)
          begin
            tick <= tick - 8'h01;
          end
          else if (!phase_hi)
          begin
            tick <= 8'(DACSW_SCLK_HALF_CYC);
            if (bits_left == 5'h00)
            begin
              // Select stays low; a short high pulse here would start a frame too early
              sync_r <= 1'b0;
              sdata_r <= 1'b0;
              o_busy <= 1'b0;
              o_done <= 1'b1;
              state <= DACSW_ST_IDLE;
            end
            else
            begin
              sclk_r <= 1'b1;
              sdata_r <= word[15];
              word <= {word[14:0], 1'b0};
              phase_hi <= 1'b1;
            end
          end
          else
          begin
            sclk_r <= 1'b0;
            bits_left <= bits_left - 5'h01;
            tick <= 8'(DACSW_SCLK_HALF_CYC);
            phase_hi <= 1'b0;
          end
        end
        default:
        begin
          state <= DACSW_ST_IDLE;
        end
      endcase
    end
  end
endmodule

/* rtl/dacsw_link_if.sv */
// Three wire write link between host and converter
// Assumes both ends share i_sys_clk in the bench
`timescale 1ns/10ps
interface dacsw_link_if;
  logic sync_n;
  logic sclk;
  logic sdata;
  modport host (output sync_n, output sclk, output sdata);
  modport dev (input sync_n, input sclk, input sdata);
endinterface

/* rtl/dacsw_pkg.sv */
// Constants shared by both ends of the serial converter link
// Assumes one system clock at 250 MHz on each end
package dacsw_pkg;
  // ------------------------------------------------------------
  // Word layout
  // ------------------------------------------------------------
  localparam int DACSW_WORD_BITS = 16;
  localparam int DACSW_CODE_BITS = 10;
  localparam int DACSW_MODE_HI_POS = 13;
  localparam int DACSW_MODE_LO_POS = 12;
  localparam int DACSW_CODE_MSB_POS = 11;
  localparam int DACSW_CODE_LSB_POS = 2;
  localparam logic [9:0] DACSW_CODE_RESET = 10'h000;
  localparam logic [1:0] DACSW_MODE_RESET = 2'h0;
  // ------------------------------------------------------------
  // Power modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    DACSW_MODE_NORMAL = 2'h0,
    DACSW_MODE_PD_1K = 2'h1,
    DACSW_MODE_PD_100K = 2'h2,
    DACSW_MODE_PD_HIZ = 2'h3
  } dacsw_mode_type;
  // ------------------------------------------------------------
  // Link timing
  // ------------------------------------------------------------
  localparam int DACSW_SYS_CLK_MHZ = 250;
  localparam int DACSW_SCLK_HALF_NS = 24;
  localparam int DACSW_SCLK_HALF_CYC = (DACSW_SCLK_HALF_NS * DACSW_SYS_CLK_MHZ) / 1000;
  localparam int DACSW_SYNC_HIGH_NS = 20;
  localparam int DACSW_SYNC_HIGH_CYC =
    (DACSW_SYNC_HIGH_NS * DACSW_SYS_CLK_MHZ + 999) / 1000;
endpackage

/* testbench/dacsw_bench.sv */
// Bench joining host and converter, plus a second converter on a bench-driven link
// Assumes 250 MHz clock and synchronous active low reset
`timescale 1ns/10ps
module dacsw_bench;
  import dacsw_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_req = 1'b0;
  logic [1:0] i_mode = 2'h0;
  logic [9:0] i_code = 10'h000;
  logic o_busy, o_done, upd, pd, pd1, pd100, pdz;
  logic [9:0] code, code_b, ec;
  logic [1:0] mode, mode_b;
  logic [1:0] tm [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
  logic [9:0] tc [5] = '{10'h3ff, 10'h155, 10'h000, 10'h2aa, 10'h2aa};
  int bad_count = 0;
  int comparisons = 0;
  int ups = 0;
  dacsw_link_if link ();
  dacsw_link_if link_b ();
  dacsw_host i_dacsw_host (.i_sys_clk, .i_nrst, .i_req, .i_mode, .i_code, .o_busy, .o_done,
    .link(link));
  dacsw_dev i_dacsw_dev (.i_sys_clk, .i_nrst, .link(link), .o_dac_code(code), .o_mode(mode),
    .o_power_down(pd), .o_pd_1k(pd1), .o_pd_100k(pd100), .o_pd_hiz(pdz), .o_update(upd));
  dacsw_dev i_dacsw_dev_b (.i_sys_clk, .i_nrst, .link(link_b), .o_dac_code(code_b),
    .o_mode(mode_b), .o_power_down(), .o_pd_1k(), .o_pd_100k(), .o_pd_hiz(), .o_update());
  dacsw_monitor i_dacsw_monitor (.i_sys_clk, .i_nrst, .sync_n(link.sync_n), .sclk(link.sclk),
    .sdata(link.sdata), .o_dac_code(code), .o_mode(mode), .o_power_down(pd), .o_pd_1k(pd1),
    .o_pd_100k(pd100), .o_pd_hiz(pdz), .o_update(upd), .o_busy, .o_done);
  // ----------------------------------------
  // Clock and helpers
  // ----------------------------------------
  initial
  begin
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) if (upd === 1'b1) ups++;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic [1:0] m, input logic [9:0] c);
    i_mode = m;
    i_code = c;
    i_req = 1'b1;
    @(posedge i_sys_clk) #1;
    i_req = 1'b0;
    for (int k = 0; k < 400 && o_done !== 1'b1; k++) @(posedge i_sys_clk) #1;
    check(o_done, 16'h0001);
    repeat (8) @(posedge i_sys_clk) #1;
  endtask
  // Bench plays host on the second link; n falls, then select rises
  task automatic raw(input logic [15:0] w, input int n);
    link_b.sync_n = 1'b1;
    #40 link_b.sync_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      #24 link_b.sdata = w[15 - (i % 16)];
      link_b.sclk = 1'b1;
      #24 link_b.sclk = 1'b0;
    end
    #40 link_b.sync_n = 1'b1;
    #40 link_b.sync_n = 1'b0;
    link_b.sdata = 1'b0;
    #40;
  endtask
  task complete_run;
    $display("comparisons %0d bad %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    link_b.sync_n = 1'b0;
    link_b.sclk = 1'b0;
    link_b.sdata = 1'b0;
    repeat (20) @(posedge i_sys_clk) #1;
    i_nrst = 1'b1;
    repeat (4) @(posedge i_sys_clk) #1;
    check(code, 16'h0);
    check(mode, 16'h0);
    ec = 10'h000;
    for (int i = 0; i < 5; i++)
    begin
      send(tm[i], tc[i]);
      if (tm[i] == 2'h0) ec = tc[i];
      check(code, ec);
      check(mode, tm[i]);
      check({pdz, pd100, pd1, pd},
        {tm[i] == 2'h3, tm[i] == 2'h2, tm[i] == 2'h1, tm[i] != 2'h0});
    end
    check(ups, 16'h0005);
    raw(16'h0b34, 16);
    check({mode_b, code_b}, 12'h2cd);
    raw(16'h3444, 15);
    check({mode_b, code_b}, 12'h2cd);
    raw(16'hc79f, 16);
    check({mode_b, code_b}, 12'h1e7);
    raw(16'h03c0, 20);
    check({mode_b, code_b}, 12'h0f0);
    complete_run;
  end
  initial
  begin
    #200000;
    bad_count++;
    complete_run;
  end
endmodule

/* testbench/dacsw_monitor.sv */
// Checker on the link and on both ends' user outputs
// Assumes one shared i_sys_clk and i_nrst
`timescale 1ns/10ps
module dacsw_monitor (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic [9:0] o_dac_code,
  input wire logic [1:0] o_mode,
  input wire logic o_power_down,
  input wire logic o_pd_1k,
  input wire logic o_pd_100k,
  input wire logic o_pd_hiz,
  input wire logic o_update,
  input wire logic o_busy,
  input wire logic o_done
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence s_gap;
    sync_n [*5];
  endsequence
  sequence s_end;
    !o_done ##0 !o_busy;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  pd_any_a: assert property (o_power_down == (o_mode != 2'h0))
    else $error("power down flag disagrees with mode");
  pd_decode_a: assert property (o_pd_1k == (o_mode == 2'h1) && o_pd_100k == (o_mode == 2'h2)
    && o_pd_hiz == (o_mode == 2'h3))
    else $error("termination select disagrees with mode");
  code_hold_a: assert property (!o_update |-> $stable(o_dac_code))
    else $error("code changed without update");
  pd_keep_a: assert property (o_update && o_mode != 2'h0 |-> $stable(o_dac_code))
    else $error("power down word changed the code");
  mode_hold_a: assert property (!o_update |-> $stable(o_mode))
    else $error("mode changed without update");
  upd_pulse_a: assert property (o_update |=> !o_update)
    else $error("update longer than one cycle");
  done_pulse_a: assert property (o_done |=> s_end)
    else $error("host still busy after done");
  idle_lines_a: assert property (!o_busy && !o_done |-> !sclk && !sdata)
    else $error("host lines not parked low when idle");
  sync_gap_a: assert property ($rose(sync_n) |-> s_gap)
    else $error("select high time too short");
endmodule
